// >>> logic/csrb_status_bank.sv
// Functional notes
// - source type in top three bits: 000 none, 001 host, 011 adapter, 111 boost
// - select pin high means 500 mA host port, low means 2.4 A adapter
// - software current limit lives elsewhere, never in the source type field
// - charge phase in bits 4:3: idle, precharge, fast, terminated
// - bit 2 reports supply good, bit 1 thermal regulation active
// - bit 0 set while held in minimum system voltage regulation
// - fault bit 7 is watchdog expiry, reads 1 after power-on
// - fault bit 6 set on any boost-invalid condition, overload or low battery
// - charge fault in bits 5:4: 00 normal, 10 thermal shutdown, 11 timer
// - fault bit 3 reports battery overvoltage
// - buck thermistor zone codes normal, warm, cool, cold, hot in bits 2:0
// - boost thermistor zone reports only normal, cold or hot
// - loop bit 7 set while input passes poor-source detection
// - loop bit 6 voltage loop active, bit 5 current loop active
// - loop bit 4 sense pin fault; then regulate at battery pin
// - loop bit 3 set while top-off timer counts
// - loop bit 2 set while input overvoltage active
// - voltage loop entry pulses interrupt unless mask bit 1 is set
// - current loop entry pulses interrupt unless mask bit 0 is set
// - restore bit write resets masks and safety timer, then self-clears
`timescale 1ns/10ps
`default_nettype none
module csrb_status_bank #(
  parameter int unsigned IRQ_PULSE_CYCLES = csrb_pkg::CSRB_IRQ_PULSE_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  // register port from the serial interface engine
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr_en,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd_en,
  output logic      [7:0] reg_rdata,
  output logic            reg_rd_valid,
  // live conditions from the power stage
  input  wire logic       boost_active,
  input  wire logic       source_present,
  input  wire logic       source_select_pin,
  input  wire logic [1:0] charge_phase_in,
  input  wire logic       supply_ok,
  input  wire logic       thermal_loop,
  input  wire logic       min_system_reg,
  input  wire logic       watchdog_expired,
  input  wire logic       otg_overload,
  input  wire logic       otg_low_battery,
  input  wire logic       input_fault,
  input  wire logic       thermal_shutdown,
  input  wire logic       safety_timer_expired,
  input  wire logic       battery_ov,
  input  wire logic       zone_warm,
  input  wire logic       zone_cool,
  input  wire logic       zone_cold,
  input  wire logic       zone_hot,
  input  wire logic       input_qualified,
  input  wire logic       input_voltage_limit_loop,
  input  wire logic       input_current_limit_loop,
  input  wire logic       battery_sense_pin_bad,
  input  wire logic       finish_timer_running,
  input  wire logic       input_overvoltage,
  // outputs to the host and the charger core
  output logic            irq_pulse,
  output logic            regulate_at_battery_pin,
  output logic            safety_timer_restart,
  output logic            voltage_loop_irq_mask,
  output logic            current_loop_irq_mask
);
  typedef struct packed {
    logic [7:0] state_status;
    logic [7:0] fault_status;
    logic [5:0] loop_status;
    logic       vmask;
    logic       imask;
    logic       prev_vloop;
    logic       prev_iloop;
    logic [7:0] rdata;
    logic       rd_valid;
    logic       timer_restart;
    logic       at_bat_pin;
    logic       irq_trigger;
  } csrb_state_t;

  csrb_state_t st;
  csrb_state_t next_st;

  logic [2:0] src_code;
  logic [1:0] fault_code;
  logic [2:0] zone_code;
  logic       boost_fault;
  logic       restore_wr;
  logic       loop_wr;
  logic       vloop_entry;
  logic       iloop_entry;
  logic [7:0] loop_read;
  logic       irq_out;

  // source type classification
  always_comb begin
    if (boost_active) begin
      src_code = csrb_pkg::CSRB_SRC_BOOST;
    end else if (!source_present) begin
      src_code = csrb_pkg::CSRB_SRC_NONE;
    end else if (source_select_pin) begin
      src_code = csrb_pkg::CSRB_SRC_HOST;
    end else begin
      src_code = csrb_pkg::CSRB_SRC_ADAPTER;
    end
    // with a source present and no boost, only the pin decides the class; the programmed limit is not folded in
  end

  // charge fault code, most severe first
  always_comb begin
    if (thermal_shutdown) begin
      fault_code = csrb_pkg::CSRB_CF_TSHUT;
    end else if (safety_timer_expired) begin
      fault_code = csrb_pkg::CSRB_CF_TIMER;
    end else if (input_fault) begin
      fault_code = csrb_pkg::CSRB_CF_INPUT;
    end else begin
      fault_code = csrb_pkg::CSRB_CF_NORMAL;
    end
  end

  // thermistor zone; boost drops warm and cool
  always_comb begin
    if (zone_hot) begin
      zone_code = csrb_pkg::CSRB_ZONE_HOT;
    end else if (zone_cold) begin
      zone_code = csrb_pkg::CSRB_ZONE_COLD;
    end else if (boost_active) begin
      zone_code = csrb_pkg::CSRB_ZONE_NORMAL;
    end else if (zone_warm) begin
      zone_code = csrb_pkg::CSRB_ZONE_WARM;
    end else if (zone_cool) begin
      zone_code = csrb_pkg::CSRB_ZONE_COOL;
    end else begin
      zone_code = csrb_pkg::CSRB_ZONE_NORMAL;
    end
  end

  assign boost_fault = otg_overload || otg_low_battery;

  assign restore_wr = reg_wr_en && (reg_addr == csrb_pkg::CSRB_OFS_RESTORE)
                      && reg_wdata[csrb_pkg::CSRB_RESTORE_BIT];
  assign loop_wr    = reg_wr_en && (reg_addr == csrb_pkg::CSRB_OFS_LOOP);

  // loop entry edges from the sampled previous level
  assign vloop_entry = input_voltage_limit_loop && !st.prev_vloop;
  assign iloop_entry = input_current_limit_loop && !st.prev_iloop;

  // loop register as the host sees it
  always_comb begin
    loop_read = {st.loop_status, st.vmask, st.imask};
  end

  always_comb begin
    next_st = st;

    // live status snapshots, refreshed every cycle
    next_st.state_status[csrb_pkg::CSRB_SRC_LSB +: 3] = src_code;
    next_st.state_status[csrb_pkg::CSRB_PHASE_LSB +: 2] = charge_phase_in;
    next_st.state_status[csrb_pkg::CSRB_PG_BIT] = supply_ok;
    next_st.state_status[csrb_pkg::CSRB_THERM_BIT] = thermal_loop;
    next_st.state_status[csrb_pkg::CSRB_MINSYS_BIT] = min_system_reg;

    next_st.fault_status[csrb_pkg::CSRB_WDOG_BIT] = watchdog_expired;
    next_st.fault_status[csrb_pkg::CSRB_BOOST_BIT] = boost_fault;
    next_st.fault_status[csrb_pkg::CSRB_CFAULT_LSB +: 2] = fault_code;
    next_st.fault_status[csrb_pkg::CSRB_BATOV_BIT] = battery_ov;
    next_st.fault_status[csrb_pkg::CSRB_ZONE_LSB +: 3] = zone_code;

    next_st.loop_status[csrb_pkg::CSRB_QUAL_BIT - 2] = input_qualified;
    next_st.loop_status[csrb_pkg::CSRB_VLOOP_BIT - 2] = input_voltage_limit_loop;
    next_st.loop_status[csrb_pkg::CSRB_ILOOP_BIT - 2] = input_current_limit_loop;
    next_st.loop_status[csrb_pkg::CSRB_SENSE_BIT - 2] = battery_sense_pin_bad;
    next_st.loop_status[csrb_pkg::CSRB_TOPOFF_BIT - 2] = finish_timer_running;
    next_st.loop_status[csrb_pkg::CSRB_OVP_BIT - 2] = input_overvoltage;

    // open sense pin moves regulation to the battery pin
    next_st.at_bat_pin = battery_sense_pin_bad;

    // only the two mask bits accept writes; restore wins over a mask write
    if (restore_wr) begin
      next_st.vmask = csrb_pkg::CSRB_MASK_RST;
      next_st.imask = csrb_pkg::CSRB_MASK_RST;
    end else if (loop_wr) begin
      next_st.vmask = reg_wdata[csrb_pkg::CSRB_VMASK_BIT];
      next_st.imask = reg_wdata[csrb_pkg::CSRB_IMASK_BIT];
    end
    // restore bit itself is never stored, so it reads back as zero
    next_st.timer_restart = restore_wr;

    // interrupt trigger on loop entry, gated by the mask in force
    next_st.prev_vloop = input_voltage_limit_loop;
    next_st.prev_iloop = input_current_limit_loop;
    next_st.irq_trigger = (vloop_entry && !st.vmask)
                          || (iloop_entry && !st.imask);

    // reads are side-effect free and see the registered snapshot
    next_st.rd_valid = reg_rd_en;
    if (reg_rd_en) begin
      unique case (reg_addr)
        csrb_pkg::CSRB_OFS_STATE: begin
          next_st.rdata = st.state_status;
        end
        csrb_pkg::CSRB_OFS_FAULT: begin
          next_st.rdata = st.fault_status;
        end
        csrb_pkg::CSRB_OFS_LOOP: begin
          next_st.rdata = loop_read;
        end
        default: begin
          next_st.rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st.state_status  <= csrb_pkg::CSRB_STATE_RST;
      st.fault_status  <= csrb_pkg::CSRB_FAULT_RST;
      st.loop_status   <= csrb_pkg::CSRB_LOOP_RST[7:2];
      st.vmask         <= csrb_pkg::CSRB_MASK_RST;
      st.imask         <= csrb_pkg::CSRB_MASK_RST;
      st.prev_vloop    <= 1'b0;
      st.prev_iloop    <= 1'b0;
      st.rdata         <= 8'h00;
      st.rd_valid      <= 1'b0;
      st.timer_restart <= 1'b0;
      st.at_bat_pin    <= 1'b0;
      st.irq_trigger   <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // stretches each trigger into a host interrupt pulse
  csrb_pulse #(
    .WIDTH (IRQ_PULSE_CYCLES)
  ) u_irq_pulse (
    .clk     (clk),
    .arst_n  (arst_n),
    .trigger (st.irq_trigger),
    .pulse   (irq_out)
  );

  assign irq_pulse               = irq_out;
  assign reg_rdata               = st.rdata;
  assign reg_rd_valid            = st.rd_valid;
  assign regulate_at_battery_pin = st.at_bat_pin;
  assign safety_timer_restart    = st.timer_restart;
  assign voltage_loop_irq_mask   = st.vmask;
  assign current_loop_irq_mask   = st.imask;
endmodule
`default_nettype wire

// >>> logic/csrb_pkg.sv
`default_nettype none
package csrb_pkg;
  // register addresses on the device register port
  localparam logic [7:0] CSRB_OFS_STATE   = 8'h08;
  localparam logic [7:0] CSRB_OFS_FAULT   = 8'h09;
  localparam logic [7:0] CSRB_OFS_LOOP    = 8'h0a;
  localparam logic [7:0] CSRB_OFS_RESTORE = 8'h0b;
  localparam int unsigned CSRB_RESTORE_BIT = 7;

  // charger_state_status fields
  localparam int unsigned CSRB_SRC_LSB   = 5;
  localparam int unsigned CSRB_PHASE_LSB = 3;
  localparam int unsigned CSRB_PG_BIT    = 2;
  localparam int unsigned CSRB_THERM_BIT = 1;
  localparam int unsigned CSRB_MINSYS_BIT = 0;

  // fault_status fields
  localparam int unsigned CSRB_WDOG_BIT   = 7;
  localparam int unsigned CSRB_BOOST_BIT  = 6;
  localparam int unsigned CSRB_CFAULT_LSB = 4;
  localparam int unsigned CSRB_BATOV_BIT  = 3;
  localparam int unsigned CSRB_ZONE_LSB   = 0;

  // loop_status_and_irq_mask fields
  localparam int unsigned CSRB_QUAL_BIT  = 7;
  localparam int unsigned CSRB_VLOOP_BIT = 6;
  localparam int unsigned CSRB_ILOOP_BIT = 5;
  localparam int unsigned CSRB_SENSE_BIT = 4;
  localparam int unsigned CSRB_TOPOFF_BIT = 3;
  localparam int unsigned CSRB_OVP_BIT   = 2;
  localparam int unsigned CSRB_VMASK_BIT = 1;
  localparam int unsigned CSRB_IMASK_BIT = 0;

  // reset values
  localparam logic [7:0] CSRB_STATE_RST = 8'h00;
  localparam logic [7:0] CSRB_FAULT_RST = 8'h80;
  localparam logic [7:0] CSRB_LOOP_RST  = 8'h00;
  localparam logic       CSRB_MASK_RST  = 1'b0;

  // input source type codes
  localparam logic [2:0] CSRB_SRC_NONE    = 3'h0;
  localparam logic [2:0] CSRB_SRC_HOST    = 3'h1;
  localparam logic [2:0] CSRB_SRC_ADAPTER = 3'h3;
  localparam logic [2:0] CSRB_SRC_BOOST   = 3'h7;

  // charge fault codes
  localparam logic [1:0] CSRB_CF_NORMAL = 2'h0;
  localparam logic [1:0] CSRB_CF_INPUT  = 2'h1;
  localparam logic [1:0] CSRB_CF_TSHUT  = 2'h2;
  localparam logic [1:0] CSRB_CF_TIMER  = 2'h3;

  // thermistor zone codes
  localparam logic [2:0] CSRB_ZONE_NORMAL = 3'h0;
  localparam logic [2:0] CSRB_ZONE_WARM   = 3'h2;
  localparam logic [2:0] CSRB_ZONE_COOL   = 3'h3;
  localparam logic [2:0] CSRB_ZONE_COLD   = 3'h5;
  localparam logic [2:0] CSRB_ZONE_HOT    = 3'h6;

  // interrupt pulse width in clock cycles
  localparam int unsigned CSRB_IRQ_PULSE_CYCLES = 4;
endpackage
`default_nettype wire

// >>> logic/csrb_pulse.sv
`timescale 1ns/10ps
`default_nettype none
module csrb_pulse #(
  parameter int unsigned WIDTH = 4
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic trigger,
  output logic      pulse
);
  localparam int unsigned CW = $clog2(WIDTH + 1);

  typedef struct packed {
    logic [CW-1:0] count;
    logic          pulse;
  } csrb_pulse_state_t;

  csrb_pulse_state_t st;
  csrb_pulse_state_t next_st;

  // a new trigger restarts the full width
  always_comb begin
    next_st = st;
    if (trigger) begin
      next_st.count = CW'(WIDTH);
    end else if (st.count != '0) begin
      next_st.count = st.count - CW'(1);
    end
    next_st.pulse = trigger || (st.count > CW'(1));
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign pulse = st.pulse;
endmodule
`default_nettype wire

// >>> sim/csrb_sva.sv
`timescale 1ns/10ps
`default_nettype none
module csrb_sva #(
  parameter int unsigned IRQ_PULSE_CYCLES = 4
) (
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr_en,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_rd_en,
  input wire logic       reg_rd_valid,
  input wire logic       input_voltage_limit_loop,
  input wire logic       input_current_limit_loop,
  input wire logic       battery_sense_pin_bad,
  input wire logic       irq_pulse,
  input wire logic       regulate_at_battery_pin,
  input wire logic       safety_timer_restart,
  input wire logic       voltage_loop_irq_mask,
  input wire logic       current_loop_irq_mask
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  int unsigned run;
  // length of the current interrupt pulse
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      run <= 0;
    end else begin
      run <= irq_pulse ? run + 1 : 0;
    end
  end
  sequence restore_s;
    reg_wr_en && reg_addr == csrb_pkg::CSRB_OFS_RESTORE && reg_wdata[7];
  endsequence
  sequence cleared_s;
    safety_timer_restart && !voltage_loop_irq_mask && !current_loop_irq_mask ##1 !safety_timer_restart;
  endsequence
  sequence mask_wr_s;
    reg_wr_en && reg_addr == csrb_pkg::CSRB_OFS_LOOP;
  endsequence
  rd_valid_a: assert property (reg_rd_valid == $past(reg_rd_en))
    else $error("read valid not one cycle after strobe");
  mask_write_a: assert property (mask_wr_s |=> {voltage_loop_irq_mask, current_loop_irq_mask} == $past(reg_wdata[1:0]))
    else $error("mask bits not taken from write");
  mask_hold_a: assert property (!reg_wr_en |=> $stable(voltage_loop_irq_mask) && $stable(current_loop_irq_mask))
    else $error("mask changed without a write");
  restore_clear_a: assert property (restore_s |=> cleared_s)
    else $error("restore did not clear masks or pulse timer restart");
  vloop_irq_a: assert property ($rose(input_voltage_limit_loop) && !voltage_loop_irq_mask |-> ##2 irq_pulse)
    else $error("no interrupt on voltage loop entry");
  iloop_irq_a: assert property ($rose(input_current_limit_loop) && !current_loop_irq_mask |-> ##2 irq_pulse)
    else $error("no interrupt on current loop entry");
  irq_masked_a: assert property ((voltage_loop_irq_mask && current_loop_irq_mask) [*7] |-> !irq_pulse)
    else $error("interrupt while both masks set");
  irq_width_a: assert property ($fell(irq_pulse) |-> run >= IRQ_PULSE_CYCLES)
    else $error("interrupt pulse too short");
  sense_copy_a: assert property (1 ##1 $stable(battery_sense_pin_bad) |-> regulate_at_battery_pin == battery_sense_pin_bad)
    else $error("regulation point does not follow sense pin state");
endmodule
bind csrb_status_bank csrb_sva #(.IRQ_PULSE_CYCLES(IRQ_PULSE_CYCLES)) u_sva (
  .clk, .arst_n, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en, .reg_rd_valid,
  .input_voltage_limit_loop, .input_current_limit_loop, .battery_sense_pin_bad, .irq_pulse,
  .regulate_at_battery_pin, .safety_timer_restart, .voltage_loop_irq_mask, .current_loop_irq_mask
);
`default_nettype wire

// >>> sim/csrb_host.sv
`timescale 1ns/10ps
`default_nettype none
module csrb_host (
  input  wire logic       clk,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rd_valid,
  output logic      [7:0] reg_addr,
  output logic            reg_wr_en,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd_en
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
  end
  // released lines show the inverse, never the last value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_en <= 1'b1;
    @(posedge clk);
    reg_wr_en <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(posedge clk);
    reg_addr <= a;
    reg_rd_en <= 1'b1;
    @(posedge clk);
    reg_rd_en <= 1'b0;
    reg_addr <= ~a;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (reg_rd_valid !== 1'b1 && n < 4);
    d = (n < 4) ? reg_rdata : 8'hxx;
  endtask
  task automatic restore();
    wr(csrb_pkg::CSRB_OFS_RESTORE, 8'h80);
  endtask
endmodule
`default_nettype wire

// >>> sim/csrb_status_bank_tb.sv
`timescale 1ns/10ps
`default_nettype none
module csrb_status_bank_tb;
  localparam int PW = 4;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [24:0] st = 25'h100;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, got;
  logic        reg_wr_en, reg_rd_en, reg_rd_valid, irq_pulse, bat_pin, tmr_rst, vmask, imask;
  logic [1:0]  mk = 2'h0;
  int          error_cnt = 0;
  int          comparisons = 0;
  always #2.5 clk = ~clk;
  csrb_status_bank #(.IRQ_PULSE_CYCLES(PW)) DUT (
    .clk, .arst_n, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en, .reg_rdata, .reg_rd_valid,
    .boost_active(st[0]), .source_present(st[1]), .source_select_pin(st[2]), .charge_phase_in(st[4:3]),
    .supply_ok(st[5]), .thermal_loop(st[6]), .min_system_reg(st[7]), .watchdog_expired(st[8]),
    .otg_overload(st[9]), .otg_low_battery(st[10]), .input_fault(st[11]), .thermal_shutdown(st[12]),
    .safety_timer_expired(st[13]), .battery_ov(st[14]), .zone_warm(st[15]), .zone_cool(st[16]),
    .zone_cold(st[17]), .zone_hot(st[18]), .input_qualified(st[19]), .input_voltage_limit_loop(st[20]),
    .input_current_limit_loop(st[21]), .battery_sense_pin_bad(st[22]), .finish_timer_running(st[23]),
    .input_overvoltage(st[24]), .irq_pulse, .regulate_at_battery_pin(bat_pin),
    .safety_timer_restart(tmr_rst), .voltage_loop_irq_mask(vmask), .current_loop_irq_mask(imask)
  );
  csrb_host u_host (.clk, .reg_rdata, .reg_rd_valid, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en);
  function automatic logic [7:0] model(input logic [7:0] a);
    logic [2:0] src;
    logic [1:0] cf;
    logic [2:0] zn;
    src = st[0] ? 3'h7 : !st[1] ? 3'h0 : st[2] ? 3'h1 : 3'h3;
    cf = st[12] ? 2'h2 : st[13] ? 2'h3 : st[11] ? 2'h1 : 2'h0;
    zn = st[18] ? 3'h6 : st[17] ? 3'h5 : st[0] ? 3'h0 : st[15] ? 3'h2 : st[16] ? 3'h3 : 3'h0;
    case (a)
      8'h08: return {src, st[4:3], st[5], st[6], st[7]};
      8'h09: return {st[8], st[9] | st[10], cf, st[14], zn};
      8'h0a: return {st[19], st[20], st[21], st[22], st[23], st[24], mk};
      default: return 8'h00;
    endcase
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #100us;
    error_cnt++;
    close_out();
  end
  initial begin
    int n;
    void'($urandom(14));
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    // power-on values, then unmapped places
    for (int a = 8; a < 13; a++) begin
      u_host.rd(8'(a), got);
      chk(got, model(8'(a)));
    end
    for (int i = 0; i < 60; i++) begin
      @(posedge clk);
      st <= 25'($urandom);
      mk = 2'($urandom);
      u_host.wr(8'h08 + 8'(i % 2), 8'($urandom));
      u_host.wr(8'h0a, {6'h3f, mk});
      for (int a = 8; a < 11; a++) begin
        u_host.rd(8'(a), got);
        chk(got, model(8'(a)));
      end
      chk({6'h0, vmask, imask}, {6'h0, mk});
      chk({7'h0, bat_pin}, {7'h0, st[22]});
      chk({7'h0, tmr_rst}, 8'h00);
    end
    u_host.wr(8'h0a, 8'h03);
    u_host.restore();
    mk = 2'h0;
    // restart pulse and cleared masks, looked at once settled
    @(negedge clk);
    chk({7'h0, tmr_rst}, 8'h01);
    chk({6'h0, vmask, imask}, 8'h00);
    u_host.rd(8'h0a, got);
    chk(got, model(8'h0a));
    st <= '0;
    // each mask setting against each loop entry
    for (int k = 0; k < 8; k++) begin
      u_host.wr(8'h0a, 8'(k / 2));
      @(posedge clk);
      st[20 + k % 2] <= 1'b1;
      n = 0;
      repeat (10) begin
        @(posedge clk);
        n += int'(irq_pulse === 1'b1);
      end
      st[20 + k % 2] <= 1'b0;
      chk(8'(n), ((k / 2) & (1 << (1 - k % 2))) != 0 ? 8'h00 : 8'(PW));
    end
    close_out();
  end
endmodule
`default_nettype wire
